// File: common/crft_cfg.svh
// register map, field positions, reset values and sizes of the rx filter
`ifndef CRFT_CFG_SVH
`define CRFT_CFG_SVH
`define CRFT_OFF_CTRL   8'h00
`define CRFT_OFF_STAT   8'h04
`define CRFT_OFF_TSH    8'h08
`define CRFT_OFF_TSL    8'h0c
`define CRFT_OFF_REL    8'h10
`define CRFT_OFF_HEAD   8'h14
`define CRFT_PAGE_CODE  3'h1
`define CRFT_PAGE_MASK  3'h2
`define CRFT_CTRL_INIT  0
`define CRFT_CTRL_LOOP  1
`define CRFT_CTRL_OVRIE 2
`define CRFT_CTRL_FM_LO 4
`define CRFT_CTRL_FM_HI 5
`define CRFT_CTRL_RST   8'h01
`define CRFT_STAT_RXF   0
`define CRFT_STAT_OVR   1
`define CRFT_STAT_HITLO 4
`define CRFT_STAT_HITHI 6
`define CRFT_STAT_CNTLO 8
`define CRFT_STAT_CNTHI 10
`define CRFT_REL_BIT    0
`define CRFT_CODE_RST   8'h00
`define CRFT_MASK_RST   8'h00
`define CRFT_TMR_RST    16'h0000
`define CRFT_FIFO_DEPTH 3'h4
`define CRFT_PTR_W      2
`define CRFT_STD_CARE32 32'hfff80000
`define CRFT_STD_CARE16 16'hfff8
`endif

// File: common/crft_pkg.sv
// types shared by the rx filter and time stamp block
`default_nettype none
package crft_pkg;
    // acceptance filter split of the code and mask banks
    typedef enum logic [1:0] {
        FM_TWO    = 2'b00,
        FM_FOUR   = 2'b01,
        FM_EIGHT  = 2'b10,
        FM_CLOSED = 2'b11
    } crft_fmode_t;

    // identifier fields of a frame seen on the bus
    typedef struct packed {
        logic [28:0] id;
        logic        ide;
        logic        rtr;
        logic        srr;
    } crft_frame_t;

    // one receive buffer: packed identifier word, hit code, stamp
    typedef struct packed {
        logic [31:0] idw;
        logic [2:0]  hit;
        logic [15:0] stamp;
    } crft_entry_t;
endpackage
`default_nettype wire

// File: dv/crft_bus_model.sv
// frame-level model of the bus side that feeds the rx filter core
`timescale 1ns/100ps
`default_nettype none
module crft_bus_model (
    // clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  nrst,
    // frame side of the core
    output var  logic                  bitTick,
    output var  logic                  frmEnd,
    output var  logic                  frmOk,
    output var  crft_pkg::crft_frame_t frmId,
    output var  logic                  txActive,
    output var  logic                  arbLost,
    input  wire logic                  ackEnable,
    // ack level seen at the end of the last frame
    output var  logic                  ackSeen
);
    logic [1:0] divQ;

    // idle levels; frame fields are meaningless until the first frame
    initial begin
        frmEnd   = 1'b0;
        frmOk    = 1'b0;
        frmId    = '0;
        txActive = 1'b0;
        arbLost  = 1'b0;
        ackSeen  = 1'b1;
    end

    // bit clock enable runs free, one tick every four system cycles
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            divQ <= 2'h0;
        end else begin
            divQ <= divQ + 2'h1;
        end
    end
    always_comb bitTick = (divQ == 2'h3);

    // one frame: tx level first, end-of-frame pulse, then release
    task automatic send(input crft_pkg::crft_frame_t f, input logic ok,
                        input logic tx, input logic lost);
        @(posedge clk_sys);
        txActive <= tx;
        arbLost  <= lost;
        @(posedge clk_sys);
        frmEnd <= 1'b1;
        frmOk  <= ok;
        frmId  <= f;
        @(posedge clk_sys);
        ackSeen  <= ackEnable;
        frmEnd   <= 1'b0;
        // released fields show garbage, not the last frame
        frmOk    <= ~ok;
        frmId    <= ~f;
        txActive <= 1'b0;
        arbLost  <= 1'b0;
        @(posedge clk_sys);
    endtask
endmodule // crft_bus_model
`default_nettype wire

// File: dv/crft_core_tb.sv
// self-checking bench for the rx filter and time stamp core
`timescale 1ns/100ps
`default_nettype none
`include "crft_cfg.svh"
module crft_core_tb;
    logic                  clk_sys;
    logic                  nrst;
    logic                  ce;
    logic                  psel;
    logic                  penable;
    logic                  pwrite;
    logic [7:0]            paddr;
    logic [31:0]           pwdata;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic                  bitTick;
    logic                  frmEnd;
    logic                  frmOk;
    logic                  txActive;
    logic                  arbLost;
    logic                  ackEnable;
    logic                  ackSeen;
    logic                  rxEvent;
    logic                  ovrEvent;
    crft_pkg::crft_frame_t frmId;
    crft_pkg::crft_frame_t fA;
    crft_pkg::crft_frame_t fB;
    crft_pkg::crft_frame_t fS;
    int                    num_errors;
    int                    check_count;
    int                    rxCnt;
    int                    ovrCnt;
    int                    expRx;
    logic [31:0]           rd;
    logic [31:0]           stA;
    logic [31:0]           stB;
    logic                  er;

    crft_core dut (.clk_sys(clk_sys), .nrst(nrst), .ce(ce), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .bitTick(bitTick), .frmEnd(frmEnd), .frmOk(frmOk), .frmId(frmId),
        .txActive(txActive), .arbLost(arbLost), .ackEnable(ackEnable),
        .rxEvent(rxEvent), .ovrEvent(ovrEvent));

    crft_bus_model bus (.clk_sys(clk_sys), .nrst(nrst), .bitTick(bitTick),
        .frmEnd(frmEnd), .frmOk(frmOk), .frmId(frmId), .txActive(txActive),
        .arbLost(arbLost), .ackEnable(ackEnable), .ackSeen(ackSeen));

    // 200 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // event pulses stand one cycle, so count them at every edge
    always @(posedge clk_sys) begin
        if (rxEvent === 1'b1) rxCnt++;
        if (ovrEvent === 1'b1) ovrCnt++;
    end

    task automatic summarize();
        $display("checks %0d, mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] r,
                       output logic e);
        int n;
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            num_errors++;
            $display("BAD at %0t: bus transfer never completed", $time);
            summarize();
        end
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rd, er);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, rd, er);
        check(rd, exp);
    endtask

    // stamps are read only for entries already handed to software
    task automatic stamp(output logic [31:0] s);
        logic [31:0] h;
        apb(1'b0, `CRFT_OFF_TSH, 32'h0, h, er);
        apb(1'b0, `CRFT_OFF_TSL, 32'h0, s, er);
        s = {16'h0, h[7:0], s[7:0]};
    endtask

    // send one frame and compare the number of queued frames
    task automatic frm(input crft_pkg::crft_frame_t f, input logic ok,
                       input logic tx, input logic lost, input logic acc);
        bus.send(f, ok, tx, lost);
        repeat (3) @(posedge clk_sys);
        expRx += int'(acc);
        check(rxCnt, expRx);
    endtask

    initial begin
        nrst    = 1'b0;
        ce      = 1'b1;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
        // id word of fA is 08 in every byte, so byte order does not matter
        fA = {29'h1000404, 1'b1, 1'b0, 1'b0};
        fB = {29'h0000000, 1'b1, 1'b0, 1'b0};
        fS = {29'h0000040, 1'b0, 1'b0, 1'b0};
        repeat (3) @(posedge clk_sys);
        nrst <= 1'b1;
        rdc(`CRFT_OFF_CTRL, 32'h1);
        rdc(`CRFT_OFF_STAT, 32'h0);
        repeat (20) @(posedge clk_sys);
        rdc(`CRFT_OFF_TSH, 32'h0);
        rdc(`CRFT_OFF_TSL, 32'h0);
        wr(`CRFT_OFF_TSL, 32'hff);
        wr(`CRFT_OFF_TSH, 32'hff);
        rdc(`CRFT_OFF_TSL, 32'h0);
        rdc(`CRFT_OFF_TSH, 32'h0);
        apb(1'b0, 8'h18, 32'h0, rd, er);
        check(rd, 32'h0);
        check(er, 32'h1);
        $display("test 1 done: reset and stamp registers");
        // bank 0 exact on fA, bank 1 fully don't care
        for (int k = 0; k < 8; k++) begin
            wr(8'h20 + 8'(4 * k), (k < 4) ? 32'h08 : 32'h00);
            wr(8'h40 + 8'(4 * k), (k < 4) ? 32'h00 : 32'hff);
        end
        wr(`CRFT_OFF_CTRL, 32'h04);
        // timer restarts at zero; let it tick before the first stamp
        repeat (8) @(posedge clk_sys);
        frm(fA, 1'b1, 1'b0, 1'b0, 1'b1);
        frm(fA, 1'b0, 1'b0, 1'b0, 1'b0);
        frm(fA, 1'b1, 1'b1, 1'b0, 1'b0);
        check(ackSeen, 32'h0);
        frm(fB, 1'b1, 1'b1, 1'b1, 1'b1);
        frm(fA | 32'h1, 1'b1, 1'b0, 1'b0, 1'b1);
        frm(fS, 1'b1, 1'b0, 1'b0, 1'b1);
        rdc(`CRFT_OFF_STAT, 32'h401);
        rdc(`CRFT_OFF_HEAD, 32'h08080808);
        $display("test 2 done: filter hits and refusals");
        frm(fA, 1'b1, 1'b0, 1'b0, 1'b0);
        check(ovrCnt, 32'h1);
        rdc(`CRFT_OFF_STAT, 32'h403);
        stamp(stA);
        check(stA != 32'h0, 32'h1);
        wr(`CRFT_OFF_REL, 32'h1);
        rdc(`CRFT_OFF_STAT, 32'h313);
        stamp(stB);
        check(stB > stA, 32'h1);
        frm(fA, 1'b1, 1'b0, 1'b0, 1'b1);
        $display("test 3 done: overrun and release");
        wr(`CRFT_OFF_REL, 32'h1);
        wr(`CRFT_OFF_CTRL, 32'h06);
        frm(fA, 1'b1, 1'b1, 1'b0, 1'b1);
        $display("test 4 done: loopback");
        wr(`CRFT_OFF_STAT, 32'h2);
        for (int k = 0; k < 8; k++) wr(8'h40 + 8'(4 * k), 32'hff);
        // standard ids go to the narrow filter modes
        for (int m = 1; m < 4; m++) begin
            wr(`CRFT_OFF_CTRL, 32'(m << 4) | 32'h1);
            wr(`CRFT_OFF_CTRL, 32'(m << 4));
            frm(fS, 1'b1, 1'b0, 1'b0, m != 3);
            rdc(`CRFT_OFF_STAT, (m == 3) ? 32'h0 : 32'h101);
        end
        $display("test 5 done: filter modes");
        summarize();
    end
endmodule // crft_core_tb
`default_nettype wire

// File: rtl/crft_core.sv
// rx acceptance filter, background buffer, rx fifo and time stamp timer
`timescale 1ns/100ps
`default_nettype none
`include "crft_cfg.svh"

// Operation
// - stamp timer free-runs on the bit clock; wraparound is not reported
// - stamp timer is held at zero during initialization mode
// - both stamp bytes are read-only; writes do nothing
// - each frame lands in the background buffer after end of frame
// - invalid or rejected frames stay out of the fifo and get overwritten
// - own frames are captured but not queued, signalled or acknowledged
// - in loopback own frames are handled like any received frame
// - on lost arbitration the winning frame is received normally
// - accepted frame into a full fifo is dropped unless a release pops in the same cycle; overrun flag always set, overrun event pulsed only if enabled
// - full fifo drops frames; acceptance resumes once a buffer frees
// - code bytes give identifier pattern; set mask bits are don't care
// - accepted frame sets buffer full flag and a three-bit hit code
// - with several matching filters the lowest number is reported
// - four filter configurations split the code and mask banks
// - two-filter mode compares extended id, rtr, ide, srr or standard id
// - two-filter mode: bytes 0-3 give hit 0, bytes 4-7 give hit 1
module crft_core (
    // clock, reset, enable
    input  wire logic                clk_sys,
    input  wire logic                nrst,
    input  wire logic                ce,
    // apb slave
    input  wire logic [7:0]          paddr,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [31:0]         pwdata,
    output var  logic [31:0]         prdata,
    output var  logic                pready,
    output var  logic                pslverr,
    // protocol engine, same clock
    input  wire logic                bitTick,
    input  wire logic                frmEnd,
    input  wire logic                frmOk,
    input  wire crft_pkg::crft_frame_t frmId,
    input  wire logic                txActive,
    input  wire logic                arbLost,
    output var  logic                ackEnable,
    // event pulses
    output var  logic                rxEvent,
    output var  logic                ovrEvent
);
    logic [7:0]  ctrl_q;
    logic [7:0]  code_q [8];
    logic [7:0]  mask_q [8];
    logic [15:0] tmr_q, txStamp_q, care16, stampSel;
    logic [31:0] prdata_q, idWord, care32, rdData;
    logic        pready_q, pslverr_q, ovr_q, moveReq_q;
    logic        rxEvent_q, ovrEvent_q, ackEn_q;
    crft_pkg::crft_entry_t bg_q;
    crft_pkg::crft_entry_t fifo_q [`CRFT_FIFO_DEPTH];
    logic [`CRFT_PTR_W-1:0] wr_q, rd_q;
    logic [2:0]  cnt_q;
    logic        initMode, loopMode, ovrIe;
    crft_pkg::crft_fmode_t fmode;
    logic [7:0]  slotHit;
    logic [2:0]  hitIdx;
    logic        anyHit, ownTx, access, wrDone;
    logic        mapped, doPush, doPop, ovrHit;
    crft_pkg::crft_entry_t head;

    assign initMode = ctrl_q[`CRFT_CTRL_INIT];
    assign loopMode = ctrl_q[`CRFT_CTRL_LOOP];
    assign ovrIe    = ctrl_q[`CRFT_CTRL_OVRIE];
    assign fmode    = crft_pkg::crft_fmode_t'(
                      ctrl_q[`CRFT_CTRL_FM_HI:`CRFT_CTRL_FM_LO]);
    assign head     = fifo_q[rd_q];
    // own frame only while we still hold the bus
    assign ownTx    = txActive & ~arbLost;

    // bus side
    assign access = ce & psel & penable;
    assign wrDone = access & pready_q & pwrite & mapped;

    // pack the identifier as the code bytes lay it out
    always_comb begin
        if (frmId.ide) begin
            idWord = {frmId.id[28:18], frmId.srr, frmId.ide,
                      frmId.id[17:0], frmId.rtr};
            care32 = 32'hffffffff;
            care16 = 16'hffff;
        end else begin
            idWord = {frmId.id[10:0], frmId.rtr, frmId.ide,
                      19'h00000};
            care32 = `CRFT_STD_CARE32;
            care16 = `CRFT_STD_CARE16;
        end
    end

    // one compare slot per filter; the mode picks which width counts
    for (genvar k = 0; k < 8; k++) begin : gFlt
        logic h32;
        logic h16;
        logic h8;
        if (k < 2) begin : gW32
            assign h32 = ((idWord ^ {code_q[4*k], code_q[4*k+1],
                          code_q[4*k+2], code_q[4*k+3]})
                         & ~{mask_q[4*k], mask_q[4*k+1],
                          mask_q[4*k+2], mask_q[4*k+3]}
                         & care32) == 32'h00000000;
        end else begin : gN32
            assign h32 = 1'b0;
        end
        if (k < 4) begin : gW16
            assign h16 = ((idWord[31:16]
                          ^ {code_q[2*k], code_q[2*k+1]})
                         & ~{mask_q[2*k], mask_q[2*k+1]}
                         & care16) == 16'h0000;
        end else begin : gN16
            assign h16 = 1'b0;
        end
        assign h8 = ((idWord[31:24] ^ code_q[k]) & ~mask_q[k])
                    == 8'h00;
        always_comb begin
            unique case (fmode)
                crft_pkg::FM_TWO:    slotHit[k] = h32;
                crft_pkg::FM_FOUR:   slotHit[k] = h16;
                crft_pkg::FM_EIGHT:  slotHit[k] = h8;
                crft_pkg::FM_CLOSED: slotHit[k] = 1'b0;
            endcase
        end
    end

    // lowest matching filter wins, so scan from the top down
    always_comb begin
        hitIdx = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (slotHit[i]) begin
                hitIdx = 3'(i);
            end
        end
    end
    assign anyHit = |slotHit;

    // stamp timer runs on bit ticks, no wrap flag exists
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            tmr_q <= `CRFT_TMR_RST;
        end else if (ce) begin
            if (initMode) begin
                tmr_q <= `CRFT_TMR_RST;
            end else if (bitTick) begin
                tmr_q <= tmr_q + 16'h0001;
            end
        end
    end

    // every frame overwrites the background buffer; only good,
    // accepted frames that are not our own, unless in loopback, ask to move on
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            bg_q      <= '0;
            moveReq_q <= 1'b0;
            txStamp_q <= `CRFT_TMR_RST;
        end else if (ce) begin
            moveReq_q <= 1'b0;
            if (frmEnd) begin
                bg_q      <= '{idw: idWord, hit: hitIdx,
                               stamp: tmr_q};
                moveReq_q <= frmOk & anyHit & ~initMode
                             & ~(ownTx & ~loopMode);
                if (ownTx) begin
                    txStamp_q <= tmr_q;
                end
            end
        end
    end

    // own frames are never acknowledged outside loopback
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ackEn_q <= 1'b1;
        end else if (ce) begin
            ackEn_q <= ~(ownTx & ~loopMode);
        end
    end

    // a pop in the same cycle makes room, so a full fifo still takes
    // the frame then
    assign doPop  = wrDone & (paddr == `CRFT_OFF_REL)
                    & pwdata[`CRFT_REL_BIT] & (cnt_q != 3'h0);
    assign doPush = moveReq_q
                    & ((cnt_q != `CRFT_FIFO_DEPTH) | doPop);
    assign ovrHit = moveReq_q & ~doPush;

    // fifo storage has no reset: contents only count below cnt_q
    always_ff @(posedge clk_sys) begin
        if (ce && doPush && !initMode) begin
            fifo_q[wr_q] <= bg_q;
        end
    end

    // fifo pointers; initialization mode flushes the queue
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= 3'h0;
        end else if (ce) begin
            if (initMode) begin
                wr_q  <= '0;
                rd_q  <= '0;
                cnt_q <= 3'h0;
            end else begin
                if (doPush) begin
                    wr_q <= wr_q + 1'b1;
                end
                if (doPop) begin
                    rd_q <= rd_q + 1'b1;
                end
                cnt_q <= cnt_q + {2'h0, doPush} - {2'h0, doPop};
            end
        end
    end

    // event pulses and sticky overrun; a new overrun beats the clear
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rxEvent_q  <= 1'b0;
            ovrEvent_q <= 1'b0;
            ovr_q      <= 1'b0;
        end else if (ce) begin
            rxEvent_q  <= doPush;
            ovrEvent_q <= ovrHit & ovrIe;
            if (ovrHit) begin
                ovr_q <= 1'b1;
            end else if (wrDone && paddr == `CRFT_OFF_STAT
                         && pwdata[`CRFT_STAT_OVR]) begin
                ovr_q <= 1'b0;
            end
        end
    end

    // stamp bytes show the head rx entry, else the last own frame;
    // software must only look for the own-frame stamp while the rx fifo reads empty
    assign stampSel = (cnt_q != 3'h0) ? head.stamp
                                      : txStamp_q;

    // read mux and decode; unaligned or unlisted addresses error
    always_comb begin
        rdData = 32'h00000000;
        mapped = 1'b1;
        if (paddr[1:0] != 2'h0) begin
            mapped = 1'b0;
        end else if (paddr[7:5] == `CRFT_PAGE_CODE) begin
            rdData[7:0] = code_q[paddr[4:2]];
        end else if (paddr[7:5] == `CRFT_PAGE_MASK) begin
            rdData[7:0] = mask_q[paddr[4:2]];
        end else begin
            case (paddr)
                `CRFT_OFF_CTRL: rdData[7:0] = ctrl_q;
                `CRFT_OFF_STAT: begin
                    rdData[`CRFT_STAT_RXF] = cnt_q != 3'h0;
                    rdData[`CRFT_STAT_OVR] = ovr_q;
                    rdData[`CRFT_STAT_HITHI:`CRFT_STAT_HITLO] = head.hit;
                    rdData[`CRFT_STAT_CNTHI:`CRFT_STAT_CNTLO] = cnt_q;
                end
                `CRFT_OFF_TSH:  rdData[7:0] = stampSel[15:8];
                `CRFT_OFF_TSL:  rdData[7:0] = stampSel[7:0];
                `CRFT_OFF_REL:  rdData = 32'h00000000;
                `CRFT_OFF_HEAD: rdData = head.idw;
                default:        mapped = 1'b0;
            endcase
        end
    end

    // one wait state: pready rises the cycle after the access starts
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h00000000;
            pslverr_q <= 1'b0;
        end else if (ce) begin
            pready_q  <= access & ~pready_q;
            if (access && !pready_q) begin
                prdata_q  <= pwrite ? 32'h00000000 : rdData;
                pslverr_q <= ~mapped;
            end else begin
                pslverr_q <= 1'b0;
            end
        end
    end

    // software registers; stamp bytes ignore writes
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ctrl_q <= `CRFT_CTRL_RST;
            for (int i = 0; i < 8; i++) begin
                code_q[i] <= `CRFT_CODE_RST;
                mask_q[i] <= `CRFT_MASK_RST;
            end
        end else if (wrDone) begin
            if (paddr == `CRFT_OFF_CTRL) begin
                ctrl_q <= pwdata[7:0];
            end
            if (paddr[7:5] == `CRFT_PAGE_CODE) begin
                code_q[paddr[4:2]] <= pwdata[7:0];
            end
            if (paddr[7:5] == `CRFT_PAGE_MASK) begin
                mask_q[paddr[4:2]] <= pwdata[7:0];
            end
        end
    end

    assign prdata    = prdata_q;
    assign pready    = pready_q;
    assign pslverr   = pslverr_q;
    assign ackEnable = ackEn_q;
    assign rxEvent   = rxEvent_q;
    assign ovrEvent  = ovrEvent_q;

    // checks beside the logic
    a_timer_init: assert property (@(posedge clk_sys) disable iff (!nrst)
        ce && initMode |=> tmr_q == 16'h0000)
        else $error("stamp timer not cleared in init mode");
    a_timer_step: assert property (@(posedge clk_sys) disable iff (!nrst)
        ce && !initMode && bitTick |=> tmr_q == $past(tmr_q) + 16'h0001)
        else $error("stamp timer did not advance");
    a_stamp_ro: assert property (@(posedge clk_sys) disable iff (!nrst)
        wrDone && !frmEnd && (paddr == `CRFT_OFF_TSH
        || paddr == `CRFT_OFF_TSL) |=> $stable(txStamp_q))
        else $error("stamp changed by a write");
    a_bad_frame: assert property (@(posedge clk_sys) disable iff (!nrst)
        ce && frmEnd && (!frmOk || !anyHit) |=> !moveReq_q)
        else $error("invalid frame queued");
    a_own_frame: assert property (@(posedge clk_sys) disable iff (!nrst)
        ce && frmEnd && ownTx && !loopMode |=> !moveReq_q && !ackEn_q)
        else $error("own frame queued or acknowledged");
    a_loop_frame: assert property (@(posedge clk_sys) disable iff (!nrst)
        ce && frmEnd && frmOk && anyHit && !initMode && loopMode
        |=> moveReq_q ##1 ce |-> rxEvent_q || ovr_q)
        else $error("loopback frame not handled");
    a_ovr_drop: assert property (@(posedge clk_sys) disable iff (!nrst)
        ce && !initMode && moveReq_q && cnt_q == `CRFT_FIFO_DEPTH
        && !doPop |=> cnt_q == `CRFT_FIFO_DEPTH && ovr_q
        && ovrEvent_q == $past(ovrIe))
        else $error("overrun not handled");
    a_push_free: assert property (@(posedge clk_sys) disable iff (!nrst)
        ce && !initMode && moveReq_q && cnt_q < `CRFT_FIFO_DEPTH
        && !doPop |=> cnt_q == $past(cnt_q) + 3'h1 && rxEvent_q)
        else $error("frame lost with room free");
    a_hit_lowest: assert property (@(posedge clk_sys) disable iff (!nrst)
        anyHit |-> slotHit[hitIdx]
        && (slotHit & ((8'h01 << hitIdx) - 8'h01)) == 8'h00)
        else $error("hit code not the lowest filter");
    a_head_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
        ce && cnt_q != 3'h0 && !doPop && !initMode
        |=> $stable(head.hit) && cnt_q != 3'h0)
        else $error("head flag or hit lost before release");
    a_apb_wait: assert property (@(posedge clk_sys) disable iff (!nrst)
        access && !pready_q |=> pready_q)
        else $error("apb answer late");
endmodule // crft_core
`default_nettype wire
